// >>> pkg/pssp_pkg.sv
// Shared constants of the pipelined static memory select port
package pssp_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 17;
    localparam int DATA_W     = 8;
    localparam int WBUF_DEPTH = 2;

    // ------------------------------------------------------------------
    // Pipeline timing (enabled clock edges from command to data phase)
    // ------------------------------------------------------------------
    localparam int DATA_PHASE_LAG = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic       RST_STAGE_VLD = 1'b0;
    localparam logic       RST_STAGE_WR  = 1'b0;
    localparam logic       RST_DRIVE     = 1'b0;
    localparam logic [7:0] RST_DOUT      = 8'h00;

    // ------------------------------------------------------------------
    // Pipeline stage opcode
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PSSP_OP_IDLE,
        PSSP_OP_READ,
        PSSP_OP_WRITE
    } pssp_op_t;

endpackage : pssp_pkg

// >>> hdl/pssp_wbuf.sv
// Small valid/ready FIFO holding captured writes, with an age-ordered view of its entries
module pssp_wbuf #(
    parameter int W     = 25,
    parameter int DEPTH = 2
) (
    input  wire logic               mclk_i,
    input  wire logic               arst_n_i,
    input  wire logic               in_valid_i,
    output logic                    in_ready_o,
    input  wire logic [W-1:0]       in_data_i,
    output logic                    out_valid_o,
    input  wire logic               out_ready_i,
    output logic [W-1:0]            out_data_o,
    output logic [DEPTH*W-1:0]      view_data_o,
    output logic [DEPTH-1:0]        view_vld_o
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0]   cnt_r;
    logic [PW:0]   cnt_nxt;
    wire           push;
    wire           pop;

    // ------------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------------
    assign in_ready_o  = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign cnt_nxt     = cnt_r + (PW+1)'(push) - (PW+1)'(pop);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            if (push) begin
                wr_ptr_r <= PW'((wr_ptr_r + 1'b1) % DEPTH);
            end
            if (pop) begin
                rd_ptr_r <= PW'((rd_ptr_r + 1'b1) % DEPTH);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // ------------------------------------------------------------------
    // Age-ordered view, entry 0 oldest
    // ------------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_view
        wire [PW-1:0] idx = PW'((rd_ptr_r + i) % DEPTH);
        assign view_data_o[i*W +: W] = mem_r[idx];
        assign view_vld_o[i]         = (cnt_r > (PW+1)'(i));
    end

endmodule : pssp_wbuf

// >>> hdl/pssp_core.sv
// Pipelined static memory with synchronous select and shared eight-bit data pins
//
// How it works
// - Deselect starts nothing; pins float two cycles on
// - Read presents addressed byte two cycles later
// - Accepted read completes even in deselected cycle
// - Pending write captured even when deselected
// - One shared bidirectional bus for both directions
// - Clock enable high freezes the pipeline and pins for that edge; buffered writes still drain
// - Output enable gates the pins asynchronously
module pssp_core #(
    parameter int ADDR_W     = pssp_pkg::ADDR_W,
    parameter int DATA_W     = pssp_pkg::DATA_W,
    parameter int WBUF_DEPTH = pssp_pkg::WBUF_DEPTH
) (
    input  wire logic              mclk_i,
    input  wire logic              arst_n_i,
    input  wire logic              clock_enable_n_i,
    input  wire logic              chip_select_n_i,
    input  wire logic              write_enable_n_i,
    input  wire logic              output_enable_n_i,
    input  wire logic [ADDR_W-1:0] word_address_i,
    input  wire logic [DATA_W-1:0] shared_data_pins_i,
    output logic      [DATA_W-1:0] shared_data_pins_o,
    output logic                   shared_data_pins_oe_o,
    input  wire logic              array_hold_i,
    output logic                   write_ready_o,
    output logic                   pipe_busy_o
);

    localparam int EW = ADDR_W + DATA_W;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [DATA_W-1:0]        array_r [2**ADDR_W];

    pssp_pkg::pssp_op_t       s1_op_r;
    pssp_pkg::pssp_op_t       s1_op_nxt;
    logic [ADDR_W-1:0]        s1_addr_r;
    pssp_pkg::pssp_op_t       s2_op_r;
    logic [ADDR_W-1:0]        s2_addr_r;

    logic [DATA_W-1:0]        dout_r;
    logic [DATA_W-1:0]        dout_nxt;
    logic                     drive_r;
    logic                     drive_nxt;

    wire                      edge_live;
    wire                      selected;
    wire                      s1_is_read;
    wire                      s2_is_write;
    wire                      wr_push;
    wire                      live_hit;

    wire                      buf_in_ready;
    wire                      buf_out_valid;
    wire  [EW-1:0]            buf_out_data;
    wire                      buf_pop;
    wire  [WBUF_DEPTH*EW-1:0] buf_view_data;
    wire  [WBUF_DEPTH-1:0]    buf_view_vld;
    logic                     buf_hit;
    logic [DATA_W-1:0]        buf_hit_data;
    logic [WBUF_DEPTH-1:0]    ent_hit;
    logic [DATA_W-1:0]        ent_data [WBUF_DEPTH];

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic op_is_read(input pssp_pkg::pssp_op_t op);
        return (op == pssp_pkg::PSSP_OP_READ);
    endfunction : op_is_read

    function automatic logic op_is_write(input pssp_pkg::pssp_op_t op);
        return (op == pssp_pkg::PSSP_OP_WRITE);
    endfunction : op_is_write

    function automatic logic op_is_busy(input pssp_pkg::pssp_op_t op);
        return (op != pssp_pkg::PSSP_OP_IDLE);
    endfunction : op_is_busy

    function automatic logic addr_match(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        return (a == b);
    endfunction : addr_match

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // Edge counts only with clock enable low
    assign edge_live = !clock_enable_n_i;
    assign selected  = edge_live && !chip_select_n_i;

    assign s1_op_nxt = !selected         ? pssp_pkg::PSSP_OP_IDLE  :
                       write_enable_n_i  ? pssp_pkg::PSSP_OP_READ  :
                                           pssp_pkg::PSSP_OP_WRITE;

    assign s1_is_read  = op_is_read(s1_op_r);
    assign s2_is_write = op_is_write(s2_op_r);

    // ------------------------------------------------------------------
    // Command pipeline
    // ------------------------------------------------------------------
    // Address travels with its opcode to the data edge
    // Two stages, advancing on live edges only
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_op_r   <= pssp_pkg::PSSP_OP_IDLE;
            s1_addr_r <= '0;
            s2_op_r   <= pssp_pkg::PSSP_OP_IDLE;
            s2_addr_r <= '0;
        end else if (edge_live) begin
            s1_op_r   <= s1_op_nxt;
            s1_addr_r <= word_address_i;
            s2_op_r   <= s1_op_r;
            s2_addr_r <= s1_addr_r;
        end
    end

    // ------------------------------------------------------------------
    // Write capture
    // ------------------------------------------------------------------
    // Data phase write taken regardless of this cycle's select
    // Byte sampled from the pins two live edges after the command
    // Write byte arrives on the shared pins
    assign wr_push = edge_live && s2_is_write;

    // A full buffer drops the byte; write_ready_o warns of it
    pssp_wbuf #(
        .W     (EW),
        .DEPTH (WBUF_DEPTH)
    ) u_wbuf (
        .mclk_i      (mclk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (wr_push),
        .in_ready_o  (buf_in_ready),
        .in_data_i   ({s2_addr_r, shared_data_pins_i}),
        .out_valid_o (buf_out_valid),
        .out_ready_i (!array_hold_i),
        .out_data_o  (buf_out_data),
        .view_data_o (buf_view_data),
        .view_vld_o  (buf_view_vld)
    );

    assign write_ready_o = buf_in_ready;
    assign buf_pop       = buf_out_valid && !array_hold_i;

    // ------------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------------
    // No reset: contents undefined until written
    always_ff @(posedge mclk_i) begin
        if (buf_pop) begin
            array_r[buf_out_data[EW-1:DATA_W]] <= buf_out_data[DATA_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Read forwarding: live write, then buffered writes, then array
    // ------------------------------------------------------------------
    assign live_hit = wr_push && addr_match(s2_addr_r, s1_addr_r);

    // Per-entry match against the address being read
    for (genvar g = 0; g < WBUF_DEPTH; g++) begin : g_fwd
        assign ent_hit[g]  = buf_view_vld[g] && addr_match(buf_view_data[g*EW+DATA_W +: ADDR_W], s1_addr_r);
        assign ent_data[g] = buf_view_data[g*EW +: DATA_W];
    end

    // Youngest matching entry wins, entry 0 being the oldest
    always_comb begin
        buf_hit      = 1'b0;
        buf_hit_data = '0;
        for (int i = 0; i < WBUF_DEPTH; i++) begin
            if (ent_hit[i]) begin
                buf_hit      = 1'b1;
                buf_hit_data = ent_data[i];
            end
        end
    end

    // Newest copy of the byte wins
    assign dout_nxt = live_hit ? shared_data_pins_i :
                      buf_hit  ? buf_hit_data       :
                                 array_r[s1_addr_r];

    // ------------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------------
    // Read loaded one live edge after acceptance
    // Loaded even if the current cycle is deselected
    // Idle or write slot floats the bus
    assign drive_nxt = s1_is_read;

    // Frozen on ignored edges so the pins hold their byte
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dout_r  <= pssp_pkg::RST_DOUT;
            drive_r <= pssp_pkg::RST_DRIVE;
        end else if (edge_live) begin
            drive_r <= drive_nxt;
            if (drive_nxt) begin
                dout_r <= dout_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    // Output enable acts without the clock
    assign shared_data_pins_oe_o = drive_r && !output_enable_n_i;
    // Read byte leaves on the same pins
    assign shared_data_pins_o    = dout_r;

    // ------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------
    // Drain of buffered writes keeps the port busy
    assign pipe_busy_o = op_is_busy(s1_op_r) || op_is_busy(s2_op_r) ||
                         buf_out_valid;

endmodule : pssp_core

// >>> bench/pssp_core_checker.sv
// Pin-level assertions for the select port
module pssp_chk #(
    parameter int DATA_W = 8
) (
    input wire logic              mclk_i,
    input wire logic              arst_n_i,
    input wire logic              clock_enable_n_i,
    input wire logic              chip_select_n_i,
    input wire logic              write_enable_n_i,
    input wire logic              output_enable_n_i,
    input wire logic              array_hold_i,
    input wire logic [DATA_W-1:0] shared_data_pins_o,
    input wire logic              shared_data_pins_oe_o,
    input wire logic              pipe_busy_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    wire live_w = !clock_enable_n_i;
    wire rd_w   = live_w && !chip_select_n_i && write_enable_n_i;
    wire wr_w   = live_w && !chip_select_n_i && !write_enable_n_i;

    AST_DESEL_FLOAT: assert property ((live_w && chip_select_n_i) ##1 live_w |=> !shared_data_pins_oe_o)
        else $error("pins driven after deselect");
    AST_READ_DRIVE: assert property (rd_w ##1 live_w |=> shared_data_pins_oe_o == !output_enable_n_i)
        else $error("read data not driven");
    AST_READ_DESEL: assert property (rd_w ##1 live_w ##1 (chip_select_n_i && !output_enable_n_i)
        |-> shared_data_pins_oe_o) else $error("read lost in deselected cycle");
    AST_WRITE_NO_DRIVE: assert property (wr_w ##1 live_w |=> !shared_data_pins_oe_o)
        else $error("device drives in write data cycle");
    AST_OE_GATE: assert property (output_enable_n_i |-> !shared_data_pins_oe_o)
        else $error("pins driven with output enable high");
    AST_CEN_FREEZE: assert property (clock_enable_n_i |=> $stable(shared_data_pins_o))
        else $error("output moved on ignored edge");
    AST_PIPE_BUSY: assert property ((live_w && !chip_select_n_i) |=> pipe_busy_o)
        else $error("accepted command not in pipeline");
    AST_WRITE_KEEP: assert property (wr_w ##1 live_w ##1 (live_w && chip_select_n_i && array_hold_i)
        |=> pipe_busy_o) else $error("deselected write data not kept");
endmodule : pssp_chk

bind pssp_core pssp_chk #(.DATA_W(DATA_W)) u_chk (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .clock_enable_n_i(clock_enable_n_i),
    .chip_select_n_i(chip_select_n_i), .write_enable_n_i(write_enable_n_i),
    .output_enable_n_i(output_enable_n_i), .array_hold_i(array_hold_i),
    .shared_data_pins_o(shared_data_pins_o), .shared_data_pins_oe_o(shared_data_pins_oe_o),
    .pipe_busy_o(pipe_busy_o)
);

// >>> bench/pssp_ctrl_model.sv
// Controller model that supplies write bytes on the shared pins
module pssp_ctrl_model (
    input  wire logic       mclk_i,
    input  wire logic       clock_enable_n_i,
    input  wire logic       chip_select_n_i,
    input  wire logic       write_enable_n_i,
    input  wire logic [7:0] wbyte_i,
    output logic      [7:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] s1_r = '0;
    logic [8:0] s2_r = '0;
    logic [7:0] last_r = '0;
    always @(posedge mclk_i) begin
        if (!clock_enable_n_i) begin
            s1_r <= {!chip_select_n_i && !write_enable_n_i, wbyte_i};
            s2_r <= s1_r;
        end
        if (s2_r[8]) last_r <= s2_r[7:0];
    end
    assign data_o = s2_r[8] ? s2_r[7:0] : ~last_r;
endmodule : pssp_ctrl_model

// >>> bench/pssp_core_tb_top.sv
// Self-checking bench for the select port
module pssp_core_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 0, arst_n = 0, cen_n = 0, cs_n = 1, we_n = 1, oe_n = 0, hold = 0;
    logic [16:0] addr = '0;
    logic [7:0] wbyte = '0, dout, mdat;
    logic [7:0] mem [32];
    logic [8:0] p1 = '0, p2 = '0;
    logic doe, wrdy, busy;
    wire [7:0] bus_w = doe ? dout : mdat;
    int errors = 0, num_checks = 0;

    pssp_core u_dut (.mclk_i(mclk), .arst_n_i(arst_n), .clock_enable_n_i(cen_n), .chip_select_n_i(cs_n),
        .write_enable_n_i(we_n), .output_enable_n_i(oe_n), .word_address_i(addr), .shared_data_pins_i(bus_w),
        .shared_data_pins_o(dout), .shared_data_pins_oe_o(doe), .array_hold_i(hold),
        .write_ready_o(wrdy), .pipe_busy_o(busy));
    pssp_ctrl_model u_mdl (.mclk_i(mclk), .clock_enable_n_i(cen_n), .chip_select_n_i(cs_n),
        .write_enable_n_i(we_n), .wbyte_i(wbyte), .data_o(mdat));

    initial forever #4 mclk = ~mclk;

    task automatic check(logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // One cycle: track and judge the data phase, then drive the next command
    task automatic step(logic c, logic s, logic w, logic [16:0] a, logic [7:0] b, logic o);
        @(posedge mclk);
        if (!cen_n) begin
            p2 = p1;
            p1 = {!cs_n && we_n, (!cs_n && we_n) ? mem[addr[4:0]] : 8'h00};
            if (!cs_n && !we_n) mem[addr[4:0]] = wbyte;
        end
        #1;
        if (p2[8]) check(dout, p2[7:0]);
        check(doe, p2[8] && !oe_n);
        {cen_n, cs_n, we_n, addr, wbyte, oe_n} = {c, s, w, a, b, o};
    endtask : step

    task automatic sc_mixed();
        for (int i = 0; i < 8; i++) step(0, 0, 0, 17'(i), 8'hA0 + 8'(i), 0);
        for (int i = 0; i < 8; i++) begin
            step(0, 0, 0, 17'(i), 8'h30 + 8'(i), 0);
            step(0, 0, 1, 17'(i), 8'h00, 0);
        end
        for (int i = 0; i < 2; i++) step(0, 1, 1, 0, 0, 0);
    endtask : sc_mixed

    task automatic sc_desel();
        step(0, 0, 1, 2, 0, 0); step(0, 1, 1, 0, 0, 0); step(0, 0, 1, 4, 0, 0); step(0, 1, 1, 0, 0, 0);
        step(0, 1, 1, 0, 0, 0); step(0, 0, 0, 9, 8'h55, 0); step(0, 1, 1, 0, 0, 0);
        step(0, 0, 0, 10, 8'h66, 0); step(0, 1, 1, 0, 0, 0); step(0, 1, 1, 0, 0, 0);
        step(0, 0, 1, 9, 0, 0); step(0, 0, 1, 10, 0, 0); step(0, 1, 1, 0, 0, 0); step(0, 1, 1, 0, 0, 0);
    endtask : sc_desel

    task automatic sc_cen();
        step(0, 0, 1, 1, 0, 0); step(1, 0, 0, 3, 8'hFF, 0); step(1, 0, 0, 3, 8'hFF, 0);
        step(0, 0, 1, 2, 0, 0); step(1, 1, 1, 0, 0, 0); step(0, 0, 0, 3, 8'h77, 0);
        step(1, 1, 1, 0, 0, 0); step(1, 1, 1, 0, 0, 0); step(0, 1, 1, 0, 0, 0); step(0, 1, 1, 0, 0, 0);
        step(0, 0, 1, 3, 0, 0); step(0, 1, 1, 0, 0, 0); step(0, 1, 1, 0, 0, 0);
    endtask : sc_cen

    task automatic sc_oe();
        step(0, 0, 1, 4, 0, 0); step(0, 1, 1, 0, 0, 0); step(0, 1, 1, 0, 0, 1);
        #1 check(doe, 1'b0);
        oe_n = 0;
        #1 check(doe, 1'b1);
        step(0, 1, 1, 0, 0, 0);
    endtask : sc_oe

    task automatic sc_hold();
        hold = 1;
        step(0, 0, 0, 20, 8'h11, 0); step(0, 1, 1, 0, 0, 0); step(0, 1, 1, 0, 0, 0);
        step(0, 0, 0, 21, 8'h22, 0); step(0, 1, 1, 0, 0, 0); step(0, 1, 1, 0, 0, 0); step(0, 1, 1, 0, 0, 0);
        check(wrdy, 1'b0);
        check(busy, 1'b1);
        hold = 0;
        for (int n = 0; n < 20 && busy !== 1'b0; n++) step(0, 1, 1, 0, 0, 0);
        if (busy !== 1'b0) begin
            errors++;
            report_and_stop();
        end
        check(wrdy, 1'b1);
        step(0, 0, 1, 20, 0, 0); step(0, 0, 1, 21, 0, 0); step(0, 1, 1, 0, 0, 0); step(0, 1, 1, 0, 0, 0);
    endtask : sc_hold

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (10) @(posedge mclk);
        #1 arst_n = 1;
        check(doe, 1'b0);
        check(wrdy, 1'b1);
        check(busy, 1'b0);
        sc_mixed();
        sc_desel();
        sc_cen();
        sc_oe();
        sc_hold();
        report_and_stop();
    end
endmodule : pssp_core_tb_top
